// >>> core/lsgc_map.vh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * link status and general-purpose output configuration block.
 * Assumes an 8-bit register port with byte offsets as printed.
 */
`ifndef LSGC_MAP_VH
`define LSGC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LSGC_OFS_RESET_CTRL  8'h03
`define LSGC_OFS_STATUS      8'h0C
`define LSGC_OFS_PAIR_LOW    8'h0D
`define LSGC_OFS_PAIR_HIGH   8'h0E

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LSGC_BIT_ERR_RESET   5
`define LSGC_BIT_RX_LOCK     4
`define LSGC_BIT_SELFTEST    3
`define LSGC_BIT_PCLK        2
`define LSGC_BIT_REMOTE_ERR  1
`define LSGC_BIT_CABLE       0
`define LSGC_BIT_HI_VALUE    7
`define LSGC_BIT_HI_REMOTE   6
`define LSGC_BIT_HI_DIR      5
`define LSGC_BIT_HI_ENABLE   4
`define LSGC_BIT_LO_VALUE    3
`define LSGC_BIT_LO_REMOTE   2
`define LSGC_BIT_LO_ENABLE   0

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define LSGC_RST_PAIR_LOW    8'h55
`define LSGC_RST_PAIR_HIGH   8'h35
`define LSGC_RST_RESET_CTRL  8'h00
`define LSGC_WR_MASK_LOW     8'hDD
`define LSGC_WR_MASK_HIGH    8'hFD
`define LSGC_WR_MASK_CTRL    8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define LSGC_CLK_PERIOD_NS   100
`define LSGC_PCLK_WINDOW_NS  1600
`define LSGC_PCLK_WINDOW_CYC (`LSGC_PCLK_WINDOW_NS / `LSGC_CLK_PERIOD_NS)
`define LSGC_PCLK_MIN_EDGES  4

`endif

// >>> core/lsgc_pin_drive.v
/*
 * One general-purpose output pin: selects local or remote value; the enable is always local, gated by the direction bit.
 * Assumes the remote value is already synchronised to core_clk.
 */
`default_nettype none
module lsgc_pin_drive (
    input  wire core_clk,     // Core clock
    input  wire resetn,       // Synchronous reset, active low
    input  wire enable,       // Pin enable bit
    input  wire remote_sel,   // Remote control bit
    input  wire dir_input,    // Direction bit, 1 = input
    input  wire local_value,  // Local value bit
    input  wire remote_value, // Value received from remote end
    output reg  pin_o,        // Pin output level
    output reg  pin_oe        // Pin output enable
);
    always @(posedge core_clk) begin
        if (!resetn) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= enable & ~dir_input;
            pin_o  <= remote_sel ? remote_value : local_value;
        end
    end
endmodule // lsgc_pin_drive
`default_nettype wire

// >>> core/lsgc_top.v
/*
 * Status register and output pin configuration registers of the serializer.
 * Assumes an 8-bit register port with write and read strobes on core_clk,
 * and link condition inputs arriving asynchronously from the analog front end.
 */
`include "lsgc_map.vh"
`default_nettype none
module lsgc_top #(
    parameter PINS = 4  // Number of output pins
) (
    input  wire       core_clk,        // 10 MHz core clock
    input  wire       resetn,          // Synchronous reset, active low
    input  wire       reg_wr,          // Register write strobe
    input  wire       reg_rd,          // Register read strobe
    input  wire [7:0] reg_addr,        // Register offset
    input  wire [7:0] reg_wdata,       // Write data
    output reg  [7:0] reg_rdata,       // Read data, valid cycle after reg_rd
    input  wire       rx_locked,       // Receive path lock, async
    input  wire       selftest_err,    // Self-test check error seen, async
    input  wire       pixel_clk,       // Incoming pixel clock, async
    input  wire       remote_err,      // Check error pulse from remote traffic, async
    input  wire       cable_ok,        // Cable present, async
    input  wire       cable_fault,     // Open, pair short, ground or battery short, async
    input  wire [3:0] remote_gpo,      // Values from remote end, async
    input  wire [3:0] pin_i,           // Pin input levels, async
    output wire [3:0] pin_o,           // Pin output levels
    output wire [3:0] pin_oe           // Pin output enables
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    reg  [9:0] sync1_q;
    reg  [9:0] sync2_q;
    reg        pclk_prev_q;
    reg        rerr_prev_q;
    wire [9:0] raw_in = {pixel_clk, remote_err, cable_fault, cable_ok, selftest_err, rx_locked, remote_gpo};

    always @(posedge core_clk) begin
        if (!resetn) begin
            sync1_q     <= 10'h000;
            sync2_q     <= 10'h000;
            pclk_prev_q <= 1'b0;
            rerr_prev_q <= 1'b0;
        end else begin
            sync1_q     <= raw_in;
            sync2_q     <= sync1_q;
            pclk_prev_q <= sync2_q[9];
            rerr_prev_q <= sync2_q[8];
        end
    end

    wire [3:0] remote_s  = sync2_q[3:0];
    wire       lock_s    = sync2_q[4];
    wire       built_in_self_test_s    = sync2_q[5];
    wire       cable_s   = sync2_q[6];
    wire       fault_s   = sync2_q[7];
    wire       rerr_rise = sync2_q[8] & ~rerr_prev_q;
    wire       pclk_rise = sync2_q[9] & ~pclk_prev_q;

    // ----------------------------------------
    // Pixel clock presence
    // ----------------------------------------
    // Counts sampled rising edges per window; a pixel clock far above the core
    // rate aliases, so this detects activity, not frequency.
    reg [7:0] win_cnt_q;
    reg [7:0] edge_cnt_q;
    reg       pclk_ok_q;

    always @(posedge core_clk) begin
        if (!resetn) begin
            win_cnt_q  <= 8'h00;
            edge_cnt_q <= 8'h00;
            pclk_ok_q  <= 1'b0;
        end else if (win_cnt_q == `LSGC_PCLK_WINDOW_CYC - 1) begin
            win_cnt_q  <= 8'h00;
            edge_cnt_q <= 8'h00;
            pclk_ok_q  <= (edge_cnt_q + {7'h00, pclk_rise}) >= `LSGC_PCLK_MIN_EDGES;
        end else begin
            win_cnt_q  <= win_cnt_q + 8'h01;
            if (pclk_rise && edge_cnt_q != 8'hFF)
                edge_cnt_q <= edge_cnt_q + 8'h01;
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    reg [7:0] ctrl_q;
    reg       lock_q;
    reg       built_in_self_test_q;
    reg       rerr_q;
    reg       cable_q;
    wire      link_up  = cable_s & ~fault_s;
    wire      err_clr  = ctrl_q[`LSGC_BIT_ERR_RESET] | ~lock_s | ~link_up;
    reg       rerr_d;

    // Clear wins over a new event: the reset bit is a level, so an event
    // landing while it is held must not leave a stale flag behind.
    always @* begin
        rerr_d = rerr_q;
        if (err_clr)
            rerr_d = 1'b0;
        else if (rerr_rise)
            rerr_d = 1'b1;
    end

    // Status is fed from link inputs and the ctrl_q error reset bit, never directly from reg_wdata.
    always @(posedge core_clk) begin
        if (!resetn) begin
            lock_q  <= 1'b0;
            built_in_self_test_q  <= 1'b0;
            rerr_q  <= 1'b0;
            cable_q <= 1'b0;
        end else begin
            lock_q  <= lock_s;
            built_in_self_test_q  <= built_in_self_test_s;
            cable_q <= link_up;
            rerr_q  <= rerr_d;
        end
    end

    wire [7:0] status = {3'b000, lock_q, built_in_self_test_q, pclk_ok_q, rerr_q, cable_q};

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    reg [7:0] pair_lo_q;
    reg [7:0] pair_hi_q;
    reg [7:0] pair_lo_d;
    reg [7:0] pair_hi_d;
    reg [7:0] ctrl_d;
    reg [7:0] rdata_d;

    // ----------------------------------------
    // Register next values
    // ----------------------------------------
    // Writes to the status offset or an unmapped offset change nothing.
    always @* begin
        pair_lo_d = pair_lo_q;
        pair_hi_d = pair_hi_q;
        ctrl_d    = ctrl_q;
        rdata_d   = reg_rdata;
        if (reg_wr) begin
            case (reg_addr)
                `LSGC_OFS_PAIR_LOW:   pair_lo_d = reg_wdata & `LSGC_WR_MASK_LOW;
                `LSGC_OFS_PAIR_HIGH:  pair_hi_d = reg_wdata & `LSGC_WR_MASK_HIGH;
                `LSGC_OFS_RESET_CTRL: ctrl_d    = reg_wdata & `LSGC_WR_MASK_CTRL;
                default:              ctrl_d    = ctrl_q;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `LSGC_OFS_STATUS:     rdata_d = status;
                `LSGC_OFS_PAIR_LOW:   rdata_d = pair_lo_q;
                `LSGC_OFS_PAIR_HIGH:  rdata_d = pair_hi_q;
                `LSGC_OFS_RESET_CTRL: rdata_d = ctrl_q;
                default:              rdata_d = 8'h00;
            endcase
        end
    end

    // Read data holds until the next read, so a slow master may sample late.
    always @(posedge core_clk) begin
        if (!resetn) begin
            pair_lo_q <= `LSGC_RST_PAIR_LOW;
            pair_hi_q <= `LSGC_RST_PAIR_HIGH;
            ctrl_q    <= `LSGC_RST_RESET_CTRL;
            reg_rdata <= 8'h00;
        end else begin
            pair_lo_q <= pair_lo_d;
            pair_hi_q <= pair_hi_d;
            ctrl_q    <= ctrl_d;
            reg_rdata <= rdata_d;
        end
    end

    // ----------------------------------------
    // Output pins
    // ----------------------------------------
    // Pin 2 field layout mirrors pin 0; only pin 3 has a direction bit.
    wire [7:0] cfg [0:1];
    assign cfg[0] = pair_lo_q;
    assign cfg[1] = pair_hi_q;

    localparam [1:0] FLD_ENABLE = 2'h0;
    localparam [1:0] FLD_REMOTE = 2'h1;
    localparam [1:0] FLD_VALUE  = 2'h2;

    // Odd pins sit in the upper nibble of their pair register.
    function pin_field;
        input [7:0] pair;
        input       upper;
        input [1:0] kind;
        begin
            case (kind)
                FLD_ENABLE: pin_field = upper ? pair[`LSGC_BIT_HI_ENABLE] : pair[`LSGC_BIT_LO_ENABLE];
                FLD_REMOTE: pin_field = upper ? pair[`LSGC_BIT_HI_REMOTE] : pair[`LSGC_BIT_LO_REMOTE];
                default:    pin_field = upper ? pair[`LSGC_BIT_HI_VALUE]  : pair[`LSGC_BIT_LO_VALUE];
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : g_pin
            localparam HI = (g % 2) == 1;
            lsgc_pin_drive u_drv (
                .core_clk     (core_clk),
                .resetn       (resetn),
                .enable       (pin_field(cfg[g/2], HI, FLD_ENABLE)),
                .remote_sel   (pin_field(cfg[g/2], HI, FLD_REMOTE)),
                .dir_input    ((g == 3) ? pair_hi_q[`LSGC_BIT_HI_DIR] : 1'b0),
                .local_value  (pin_field(cfg[g/2], HI, FLD_VALUE)),
                .remote_value (remote_s[g]),
                .pin_o        (pin_o[g]),
                .pin_oe       (pin_oe[g])
            );
        end
    endgenerate

    // pin_i is accepted for a future readback of pin 3 when set as input.
    wire unused_pin_i = ^pin_i;
endmodule // lsgc_top
`default_nettype wire

// >>> test/lsgc_checker.sv
/* Port checks on lsgc_top.
   Assumes a bind from tb with all ports by name. */
`default_nettype none
module lsgc_checker (
    input wire logic       core_clk,     // Clock
    input wire logic       resetn,       // Reset, active low
    input wire logic       reg_wr,       // Write strobe
    input wire logic       reg_rd,       // Read strobe
    input wire logic [7:0] reg_addr,     // Offset
    input wire logic [7:0] reg_wdata,    // Write data
    input wire logic [7:0] reg_rdata,    // Read data
    input wire logic       rx_locked,    // Lock
    input wire logic       selftest_err, // Self-test error
    input wire logic       cable_ok,     // Cable
    input wire logic       cable_fault,  // Fault
    input wire logic [3:0] pin_o,        // Pin levels
    input wire logic [3:0] pin_oe        // Pin enables
);
    timeunit 1ns;
    timeprecision 1ns;
    wire rd_st = reg_rd && reg_addr == 8'h0C;
    wire wr_lo = reg_wr && reg_addr == 8'h0D;
    wire wr_hi = reg_wr && reg_addr == 8'h0E;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Inputs pass three flops, so four steady cycles give a settled flag
    a_lock_flag:
    assert property ($stable(rx_locked) [*4] ##0 rd_st |=> reg_rdata[4] == $past(rx_locked)) else $error("lock flag");
    a_test_flag:
    assert property ($stable(selftest_err) [*4] ##0 rd_st |=> reg_rdata[3] == $past(selftest_err))
        else $error("self-test flag");
    a_cable_flag:
    assert property (($stable(cable_ok) && $stable(cable_fault)) [*4] ##0 rd_st
        |=> reg_rdata[0] == $past(cable_ok && !cable_fault)) else $error("cable flag");
    a_fault_clear:
    assert property (cable_fault [*4] ##0 rd_st |=> !reg_rdata[0]) else $error("fault kept link");
    a_oe_low:
    assert property (wr_lo ##1 !wr_lo |=> pin_oe[1:0] == {$past(reg_wdata[4], 2), $past(reg_wdata[0], 2)})
        else $error("low pair enable");
    a_oe_high:
    assert property (wr_hi ##1 !wr_hi |=> pin_oe[3] == ($past(reg_wdata[4], 2) && !$past(reg_wdata[5], 2)))
        else $error("pin3 enable");
    a_local_pin0:
    assert property (wr_lo && !reg_wdata[2] ##1 !wr_lo |=> pin_o[0] == $past(reg_wdata[3], 2)) else $error("pin0 local");
    a_local_pin3:
    assert property (wr_hi && !reg_wdata[6] ##1 !wr_hi |=> pin_o[3] == $past(reg_wdata[7], 2)) else $error("pin3 local");
endmodule // lsgc_checker
`default_nettype wire

// >>> test/lsgc_remote_model.sv
/* Remote deserializer end: forwarded pin values and error events.
   Assumes the bench calls its tasks at the falling clock edge. */
`default_nettype none
module lsgc_remote_model (
    input  wire logic       core_clk,   // Clock
    output var  logic [3:0] remote_gpo, // Forwarded values
    output var  logic       remote_err  // Error event
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        remote_gpo = 4'h0;
        remote_err = 1'b0;
    end
    // Far side has its own timing, so values land off our edges
    task automatic send_gpo(input logic [3:0] v);
        #13 remote_gpo = v;
    endtask
    // One rising edge per error, held long enough to be synced
    task automatic send_error();
        remote_err = 1'b1;
        repeat (3) @(posedge core_clk);
        #7 remote_err = 1'b0;
    endtask
endmodule // lsgc_remote_model
`default_nettype wire

// >>> test/tb.sv
/* Bench for lsgc_top: register tasks, status and pin tests.
   Assumes design, checker and remote model compiled first. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk, resetn, reg_wr, reg_rd, rx_locked, selftest_err, pixel_clk, cable_ok, cable_fault, pclk_run;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] pin_o, pin_oe;
    wire  [3:0] remote_gpo;
    wire        remote_err;
    int         num_errors, cmp_count;
    lsgc_top u_dut (.core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_locked(rx_locked), .selftest_err(selftest_err),
        .pixel_clk(pixel_clk), .remote_err(remote_err), .cable_ok(cable_ok), .cable_fault(cable_fault),
        .remote_gpo(remote_gpo), .pin_i(4'h0), .pin_o(pin_o), .pin_oe(pin_oe));
    lsgc_remote_model u_remote (.core_clk(core_clk), .remote_gpo(remote_gpo), .remote_err(remote_err));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Slow enough that every level is sampled; a fast clock aliases in the detector
    always #120 if (pclk_run) pixel_clk = ~pixel_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp, what);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #1ms;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {reg_wr, reg_rd, rx_locked, selftest_err, pixel_clk, cable_ok, cable_fault, pclk_run} = '0;
        {reg_addr, reg_wdata} = 16'h0000;
        num_errors = 0;
        cmp_count = 0;
        resetn = 1'b0;
        idle(2);
        resetn = 1'b1;
        rd(8'h0D, 8'h55, "low pair reset");
        rd(8'h0E, 8'h35, "high pair reset");
        chk({4'h0, pin_oe}, 8'h07, "reset enables");
        $display("test reset_defaults done");
        {rx_locked, selftest_err, cable_ok, pclk_run} = 4'hF;
        idle(40);
        rd(8'h0C, 8'h1D, "status up");
        wr(8'h0C, 8'h00);
        rd(8'h0C, 8'h1D, "status after write");
        u_remote.send_error();
        idle(4);
        rd(8'h0C, 8'h1F, "remote error");
        wr(8'h03, 8'h20);
        wr(8'h03, 8'h00);
        idle(3);
        rd(8'h0C, 8'h1D, "error reset");
        u_remote.send_error();
        idle(4);
        rd(8'h0C, 8'h1F, "remote error again");
        cable_fault = 1'b1;
        idle(4);
        rd(8'h0C, 8'h1C, "cable fault");
        cable_fault = 1'b0;
        {rx_locked, selftest_err, cable_ok, pclk_run} = 4'h0;
        idle(40);
        rd(8'h0C, 8'h00, "status down");
        $display("test status done");
        wr(8'h0D, 8'h99);
        wr(8'h0E, 8'h90);
        idle(3);
        chk({pin_oe, pin_o}, 8'hBB, "local drive");
        wr(8'h0D, 8'h11);
        wr(8'h0E, 8'hB0);
        idle(3);
        chk({pin_oe, pin_o}, 8'h38, "local low, pin3 input");
        wr(8'h0D, 8'h55);
        wr(8'h0E, 8'h55);
        u_remote.send_gpo(4'hA);
        idle(4);
        chk({pin_oe, pin_o}, 8'hFA, "remote A");
        u_remote.send_gpo(4'h5);
        idle(4);
        chk({pin_oe, pin_o}, 8'hF5, "remote 5");
        wr(8'h0D, 8'hFF);
        rd(8'h0D, 8'hDD, "reserved masked");
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00, "unmapped");
        $display("test pins done");
        tally_and_finish();
    end
endmodule // tb
bind lsgc_top lsgc_checker u_chk (.core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_locked(rx_locked),
    .selftest_err(selftest_err), .cable_ok(cable_ok), .cable_fault(cable_fault), .pin_o(pin_o), .pin_oe(pin_oe));
`default_nettype wire
